// file: pkg/imsk_pkg.sv
// Package holding the register map, bit positions, reset values and carrier types of the interrupt mask block.
package imsk_pkg;

  // Register byte addresses on the internal register port.
  localparam logic [31:0] ADDR_MASKED_STATUS = 32'h5000132C;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h50001330;
  localparam logic [31:0] ADDR_IRQ_RAW_STATUS = 32'h50001334;
  localparam logic [31:0] ADDR_CLEAR_ALL = 32'h50001340;
  localparam logic [31:0] ADDR_CLEAR_READ_REQUEST = 32'h50001350;
  localparam logic [31:0] ADDR_CLEAR_ABORT = 32'h50001354;
  localparam logic [31:0] ADDR_CLEAR_BUS_BUSY = 32'h5000135C;
  localparam logic [31:0] ADDR_CLEAR_GENERAL_CALL = 32'h50001368;

  // Bit positions within the mask and status registers.
  localparam int BIT_GENERAL_CALL = 11;
  localparam int BIT_START_SEEN = 10;
  localparam int BIT_STOP_SEEN = 9;
  localparam int BIT_BUS_BUSY = 8;
  localparam int BIT_SLAVE_DONE = 7;
  localparam int BIT_TX_ABORTED = 6;
  localparam int BIT_READ_REQUEST = 5;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_TX_OVERFLOW = 3;
  localparam int BIT_RX_FULL = 2;
  localparam int BIT_RX_OVERFLOW = 1;
  localparam int BIT_RX_UNDER = 0;

  // Reset and writable fields of the mask register, and the raw status reset value.
  localparam logic [15:0] MASK_RESET = 16'h08FF;
  localparam logic [15:0] MASK_WRITABLE = 16'h0FFF;
  localparam logic [15:0] RAW_RESET = 16'h0000;

  // Buffer depth used by the overflow checks.
  localparam logic [5:0] FIFO_DEPTH = 6'h20;

  // Pin indices in the synchroniser vector.
  localparam int PIN_SCL = 1;
  localparam int PIN_SDA = 0;

  // Event strobes and levels from the surrounding controller.
  typedef struct packed {
    logic general_call;
    logic slave_nack;
    logic tx_abort;
    logic read_request;
    logic tx_write;
    logic rx_byte;
    logic rx_full;
    logic rx_under;
  } imsk_evt_t;

  // State of the pin synchroniser.
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } imsk_sync_t;

  // State of the status and mask block.
  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] raw;
    logic [15:0] rdata;
    logic [1:0] prev_lvl;
    logic irq;
    logic scl_oe;
    logic tx_flush;
    logic rx_drop;
  } imsk_state_t;

endpackage

// file: rtl/imsk_pin_sync.sv
// Three-stage synchroniser with agreement filter for the two serial bus pins.
`timescale 1ns/1ps
module imsk_pin_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Raw pins, clock line in bit 1 and data line in bit 0.
  input wire logic [1:0] pin_raw,
  // Filtered pin levels.
  output logic [1:0] pin_lvl
);

  imsk_pkg::imsk_sync_t s_q;
  imsk_pkg::imsk_sync_t s_d;

  // The first stage feeds only the second; a level is accepted once stages two and three agree.
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pin_raw;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.s2[i] == s_q.s3[i])
      begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  // Idle bus lines rest high, so reset to high.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, lvl: 2'h3};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pin_lvl = s_q.lvl;

endmodule

// file: rtl/imsk_status.sv
// Interrupt mask and raw status logic of the two-wire bus controller.
// Contract
// R1: Mask bits 11..0 gate raw bits into masked view; bits 15..12 read zero.
// R2: Mask resets to ones for general call and bits 7..0, zeros otherwise.
// R3: General call flag sets on acknowledged general call; clears on disable or clear read.
// R4: Start flag sets on every START or repeated START.
// R5: Stop flag sets on every STOP condition.
// R6: Activity flag sticky; clears on disable, busy clear, combined clear or reset.
// R7: Done flag sets when remote master does not acknowledge a slave-sent byte.
// R8: Abort flag sets when queued transmit actions cannot complete.
// R9: While abort set, transmit buffer is flushed until abort clear read.
// R10: Read request flag sets on slave read address; clock line held low meanwhile.
// R11: Software writes the requested byte so the stalled transfer proceeds; here a write leaves the clock held until the request is cleared.
// R12: Read request flag returns to zero right after its clear register is read.
// R13: Transmit empty is one while level at or below threshold.
// R14: Disabled: buffer flushed; empty reads activity of state machines.
// R15: Transmit overflow on write with 32 entries; clears when disabled and idle.
// R16: Receive overflow on byte arriving with 32 entries; byte acknowledged, dropped.
// R17: Interrupt output high whenever any masked status bit is set.
`timescale 1ns/1ps
module imsk_status (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Internal register port.
  input wire logic [31:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Controller state and events.
  input wire logic controller_on,
  input wire logic sm_active,
  input wire logic [5:0] tx_level,
  input wire logic [4:0] tx_threshold,
  input wire logic [5:0] rx_level,
  input wire imsk_pkg::imsk_evt_t evt,
  // Serial bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  // Buffer control and interrupt.
  output logic tx_flush,
  output logic rx_drop,
  output logic irq
);

  imsk_pkg::imsk_state_t s_q;
  imsk_pkg::imsk_state_t s_d;
  logic [1:0] lvl;
  logic scl_now;
  logic sda_now;
  logic start_ev;
  logic stop_ev;
  logic pin_change;
  logic clr_all;
  logic clr_rdreq;
  logic clr_abort;
  logic clr_busy;
  logic clr_gc;
  logic dis_idle;
  logic tx_over_ev;
  logic rx_over_ev;

  // Pin levels come through the three-stage filter.
  imsk_pin_sync u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_raw({scl_i, sda_i}),
    .pin_lvl(lvl)
  );

  // Bus conditions: data edges while the clock line stays high.
  assign scl_now = lvl[imsk_pkg::PIN_SCL];
  assign sda_now = lvl[imsk_pkg::PIN_SDA];
  assign start_ev = s_q.prev_lvl[imsk_pkg::PIN_SDA] & ~sda_now & scl_now & s_q.prev_lvl[imsk_pkg::PIN_SCL];
  assign stop_ev = ~s_q.prev_lvl[imsk_pkg::PIN_SDA] & sda_now & scl_now & s_q.prev_lvl[imsk_pkg::PIN_SCL];
  assign pin_change = (lvl != s_q.prev_lvl);

  // Read-triggered clears; reads of clear registers have this side effect.
  assign clr_all = reg_rd && (reg_addr == imsk_pkg::ADDR_CLEAR_ALL);
  assign clr_rdreq = clr_all || (reg_rd && (reg_addr == imsk_pkg::ADDR_CLEAR_READ_REQUEST));
  assign clr_abort = clr_all || (reg_rd && (reg_addr == imsk_pkg::ADDR_CLEAR_ABORT));
  assign clr_busy = clr_all || (reg_rd && (reg_addr == imsk_pkg::ADDR_CLEAR_BUS_BUSY));
  assign clr_gc = clr_all || (reg_rd && (reg_addr == imsk_pkg::ADDR_CLEAR_GENERAL_CALL));
  assign dis_idle = !controller_on && !sm_active;
  assign tx_over_ev = evt.tx_write && (tx_level == imsk_pkg::FIFO_DEPTH);
  assign rx_over_ev = evt.rx_byte && (rx_level == imsk_pkg::FIFO_DEPTH);

  // Next-state logic; in every flag the set term is applied after the clear so a same-cycle event wins.
  always_comb
  begin
    s_d = s_q;
    s_d.prev_lvl = lvl;
    // R1: mask write path
    if (reg_wr && (reg_addr == imsk_pkg::ADDR_IRQ_MASK))
    begin
      s_d.mask = reg_wdata & imsk_pkg::MASK_WRITABLE;
    end
    // R3: general call flag
    if (clr_gc || !controller_on)
    begin
      s_d.raw[imsk_pkg::BIT_GENERAL_CALL] = 1'b0;
    end
    if (evt.general_call)
    begin
      s_d.raw[imsk_pkg::BIT_GENERAL_CALL] = 1'b1;
    end
    // R4: start seen flag
    if (clr_all)
    begin
      s_d.raw[imsk_pkg::BIT_START_SEEN] = 1'b0;
      s_d.raw[imsk_pkg::BIT_STOP_SEEN] = 1'b0;
      s_d.raw[imsk_pkg::BIT_SLAVE_DONE] = 1'b0;
      s_d.raw[imsk_pkg::BIT_TX_OVERFLOW] = 1'b0;
      s_d.raw[imsk_pkg::BIT_RX_OVERFLOW] = 1'b0;
    end
    if (start_ev)
    begin
      s_d.raw[imsk_pkg::BIT_START_SEEN] = 1'b1;
    end
    // R5: stop seen flag
    if (stop_ev)
    begin
      s_d.raw[imsk_pkg::BIT_STOP_SEEN] = 1'b1;
    end
    // R6: sticky activity flag
    if (clr_busy || !controller_on)
    begin
      s_d.raw[imsk_pkg::BIT_BUS_BUSY] = 1'b0;
    end
    if (pin_change || sm_active)
    begin
      s_d.raw[imsk_pkg::BIT_BUS_BUSY] = 1'b1;
    end
    // R7: slave transmit done
    if (evt.slave_nack)
    begin
      s_d.raw[imsk_pkg::BIT_SLAVE_DONE] = 1'b1;
    end
    // R8: transmit abort flag
    if (clr_abort)
    begin
      s_d.raw[imsk_pkg::BIT_TX_ABORTED] = 1'b0;
    end
    if (evt.tx_abort)
    begin
      s_d.raw[imsk_pkg::BIT_TX_ABORTED] = 1'b1;
    end
    // R12: read request clear
    if (clr_rdreq)
    begin
      s_d.raw[imsk_pkg::BIT_READ_REQUEST] = 1'b0;
    end
    // R10: read request flag
    if (evt.read_request)
    begin
      s_d.raw[imsk_pkg::BIT_READ_REQUEST] = 1'b1;
    end
    // R13: transmit empty tracks level
    // R14: disabled view follows activity
    if (controller_on)
    begin
      s_d.raw[imsk_pkg::BIT_TX_EMPTY] = (tx_level <= {1'b0, tx_threshold});
    end
    else
    begin
      s_d.raw[imsk_pkg::BIT_TX_EMPTY] = sm_active;
    end
    // R15: transmit overflow flag
    if (dis_idle)
    begin
      s_d.raw[imsk_pkg::BIT_TX_OVERFLOW] = 1'b0;
      s_d.raw[imsk_pkg::BIT_RX_OVERFLOW] = 1'b0;
    end
    if (tx_over_ev)
    begin
      s_d.raw[imsk_pkg::BIT_TX_OVERFLOW] = 1'b1;
    end
    // R16: receive overflow flag
    if (rx_over_ev)
    begin
      s_d.raw[imsk_pkg::BIT_RX_OVERFLOW] = 1'b1;
    end
    s_d.rx_drop = rx_over_ev;
    // Lower status levels are owned elsewhere and mirrored here; receive full is forced low while disabled.
    s_d.raw[imsk_pkg::BIT_RX_FULL] = evt.rx_full && controller_on;
    s_d.raw[imsk_pkg::BIT_RX_UNDER] = evt.rx_under;
    // R9: flush while aborted or disabled
    s_d.tx_flush = s_d.raw[imsk_pkg::BIT_TX_ABORTED] || !controller_on;
    // R10: stretch clock low while request pending
    s_d.scl_oe = s_d.raw[imsk_pkg::BIT_READ_REQUEST];
    // R17: combined masked interrupt
    s_d.irq = |(s_d.raw & s_d.mask);
    // Register read data; unmapped and clear addresses return the flag or zero.
    if (reg_rd)
    begin
      if (reg_addr == imsk_pkg::ADDR_IRQ_MASK)
      begin
        s_d.rdata = s_q.mask;
      end
      else if (reg_addr == imsk_pkg::ADDR_IRQ_RAW_STATUS)
      begin
        s_d.rdata = s_q.raw;
      end
      else if (reg_addr == imsk_pkg::ADDR_MASKED_STATUS)
      begin
        // R1: masked status view
        s_d.rdata = s_q.raw & s_q.mask;
      end
      else if (reg_addr == imsk_pkg::ADDR_CLEAR_READ_REQUEST)
      begin
        s_d.rdata = {15'h0000, s_q.raw[imsk_pkg::BIT_READ_REQUEST]};
      end
      else if (reg_addr == imsk_pkg::ADDR_CLEAR_ABORT)
      begin
        s_d.rdata = {15'h0000, s_q.raw[imsk_pkg::BIT_TX_ABORTED]};
      end
      else
      begin
        s_d.rdata = 16'h0000;
      end
    end
  end

  // One register stage for all state; the mask takes its own reset value, not all zeros.
  // R2: mask reset value
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_q <= '{mask: imsk_pkg::MASK_RESET, raw: imsk_pkg::RAW_RESET, rdata: 16'h0000,
               prev_lvl: 2'h3, irq: 1'b0, scl_oe: 1'b0, tx_flush: 1'b1, rx_drop: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs other than scl_o come straight from the state register; scl_o is tied low, so the clock line is only ever pulled low.
  assign reg_rdata = s_q.rdata;
  assign scl_o = 1'b0;
  assign scl_oe = s_q.scl_oe;
  assign tx_flush = s_q.tx_flush;
  assign rx_drop = s_q.rx_drop;
  assign irq = s_q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence seq_rdreq_held;
    s_q.raw[imsk_pkg::BIT_READ_REQUEST] && scl_oe;
  endsequence

  chk_reserved_zero: assert property (s_q.mask[15:12] == 4'h0 && s_q.raw[15:12] == 4'h0) // R1
    else $error("reserved bits not zero");
  chk_mask_reset_value: assert property ($past(srst) |-> s_q.mask == imsk_pkg::MASK_RESET) // R2
    else $error("mask reset value wrong");
  chk_general_call_set: assert property (evt.general_call |=> s_q.raw[imsk_pkg::BIT_GENERAL_CALL]) // R3
    else $error("general call flag missed");
  chk_start_seen_set: assert property (start_ev |=> s_q.raw[imsk_pkg::BIT_START_SEEN]) // R4
    else $error("start flag missed");
  chk_stop_seen_set: assert property (stop_ev |=> s_q.raw[imsk_pkg::BIT_STOP_SEEN]) // R5
    else $error("stop flag missed");
  chk_activity_sticky: assert property (s_q.raw[imsk_pkg::BIT_BUS_BUSY] && controller_on && !clr_busy
    |=> s_q.raw[imsk_pkg::BIT_BUS_BUSY]) // R6
    else $error("activity flag dropped");
  chk_slave_done_set: assert property (evt.slave_nack |=> s_q.raw[imsk_pkg::BIT_SLAVE_DONE]) // R7
    else $error("done flag missed");
  chk_abort_flushes: assert property (evt.tx_abort |=> s_q.raw[imsk_pkg::BIT_TX_ABORTED] && tx_flush) // R8
    else $error("abort flag or flush missed");
  chk_abort_flush_hold: assert property (s_q.raw[imsk_pkg::BIT_TX_ABORTED] |-> tx_flush) // R9
    else $error("flush released while aborted");
  chk_rdreq_stretch: assert property (evt.read_request |=> seq_rdreq_held) // R10
    else $error("read request not holding clock");
  chk_rdreq_clear: assert property (clr_rdreq && !evt.read_request
    |=> !s_q.raw[imsk_pkg::BIT_READ_REQUEST] && !scl_oe) // R12
    else $error("read request not cleared");
  chk_tx_empty_level: assert property (controller_on |=> s_q.raw[imsk_pkg::BIT_TX_EMPTY]
    == ($past(tx_level) <= {1'b0, $past(tx_threshold)})) // R13
    else $error("transmit empty wrong");
  chk_disabled_empty: assert property (!controller_on |=> s_q.raw[imsk_pkg::BIT_TX_EMPTY] == $past(sm_active)
    && tx_flush) // R14
    else $error("disabled empty view wrong");
  chk_tx_overflow: assert property (tx_over_ev |=> s_q.raw[imsk_pkg::BIT_TX_OVERFLOW]) // R15
    else $error("transmit overflow missed");
  chk_rx_overflow: assert property (rx_over_ev |=> s_q.raw[imsk_pkg::BIT_RX_OVERFLOW] && rx_drop) // R16
    else $error("receive overflow missed");
  chk_irq_combined: assert property (irq == |(s_q.raw & s_q.mask)) // R17
    else $error("interrupt output mismatch");

endmodule

// file: sim/imsk_bus_model.sv
// Remote bus party that makes START and STOP conditions on the two open-drain lines.
`timescale 1ns/1ps
module imsk_bus_model (
  // Clock line drive value and pull-low enable from the device.
  input wire logic scl_o,
  input wire logic scl_oe,
  // Resolved line levels.
  output logic scl_line,
  output logic sda_line
);
  logic scl_pull;
  logic sda_pull;
  // Pull-ups make a released line read high, so no stale level survives.
  assign scl_line = !(scl_pull || (scl_oe && !scl_o));
  assign sda_line = !sda_pull;
  // Both lines are released until a frame begins.
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Data falls while the clock is high, then the clock is parked low.
  task automatic send_start();
    sda_pull = 1'b1;
    #62.5;
    scl_pull = 1'b1;
    #62.5;
  endtask
  // Clock is released first, then data rises while the clock is high.
  task automatic send_stop();
    scl_pull = 1'b0;
    wait (scl_line === 1'b1);
    #62.5;
    sda_pull = 1'b0;
    #62.5;
  endtask
endmodule

// file: sim/tb_imsk_status.sv
// Self-checking bench for the interrupt mask and raw status block.
`timescale 1ns/1ps
module tb_imsk_status;
  logic clk_sys;
  logic srst;
  logic [31:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic controller_on;
  logic sm_active;
  logic [5:0] tx_level;
  logic [4:0] tx_threshold;
  logic [5:0] rx_level;
  imsk_pkg::imsk_evt_t evt;
  logic scl_line;
  logic sda_line;
  logic scl_oe;
  logic scl_o;
  logic tx_flush;
  logic rx_drop;
  logic irq;
  logic [15:0] d;
  int err_total;
  int check_count;

  imsk_status i_dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .controller_on(controller_on), .sm_active(sm_active),
    .tx_level(tx_level), .tx_threshold(tx_threshold), .rx_level(rx_level), .evt(evt),
    .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .tx_flush(tx_flush), .rx_drop(rx_drop), .irq(irq)
  );
  imsk_bus_model i_bus (.scl_o(scl_o), .scl_oe(scl_oe), .scl_line(scl_line), .sda_line(sda_line));

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Every step starts one nanosecond after a rising edge.
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A read leaves its data in d; read strobes never touch back to back.
  task automatic rd(input logic [31:0] a);
    tick();
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    tick();
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask
  // One-cycle event strobe, index 0 is the most significant field.
  task automatic pulse(input int i);
    tick();
    evt = imsk_pkg::imsk_evt_t'(8'h80 >> i);
    tick();
    evt = '0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset values, writable field and an unmapped place.
  task automatic t_regs();
    rd(imsk_pkg::ADDR_IRQ_MASK);
    chk("mask reset", d, 16'h08FF);
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("raw reset", d, 16'h0010);
    wr(imsk_pkg::ADDR_IRQ_MASK, 16'hFFFF);
    wr(32'h50001338, 16'h0000);
    rd(imsk_pkg::ADDR_IRQ_MASK);
    chk("mask upper", d, 16'h0FFF);
    rd(32'h50001338);
    chk("unmapped", d, 16'h0000);
    $display("t_regs done");
  endtask

  // General call, done, abort and read request each alone in the mask drive the interrupt and masked view.
  task automatic t_flags();
    int bits[4] = '{11, 7, 6, 5};
    for (int i = 0; i < 4; i++)
    begin
      wr(imsk_pkg::ADDR_IRQ_MASK, 16'h0001 << bits[i]);
      tick();
      chk("irq idle", irq, 1'b0);
      pulse(i);
      chk("irq set", irq, 1'b1);
      rd(imsk_pkg::ADDR_MASKED_STATUS);
      chk("masked", d, 16'h0001 << bits[i]);
    end
    chk("flush", tx_flush, 1'b1);
    chk("stretch", scl_line, 1'b0);
    pulse(4);
    chk("stretch kept", scl_oe, 1'b1);
    // The software side services the request by clearing it.
    rd(imsk_pkg::ADDR_CLEAR_READ_REQUEST);
    chk("rdreq old", d, 16'h0001);
    chk("stretch off", scl_oe, 1'b0);
    rd(imsk_pkg::ADDR_CLEAR_ABORT);
    tick();
    chk("flush off", tx_flush, 1'b0);
    rd(imsk_pkg::ADDR_CLEAR_GENERAL_CALL);
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("raw left", d & 16'h08E0, 16'h0080);
    $display("t_flags done");
  endtask

  // START and STOP from the remote party, then the activity and combined clears.
  task automatic t_bus();
    i_bus.send_start();
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("start", d & 16'h0700, 16'h0500);
    i_bus.send_stop();
    repeat (8) tick();
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("stop", d & 16'h0700, 16'h0700);
    rd(imsk_pkg::ADDR_CLEAR_BUS_BUSY);
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("busy clr", d & 16'h0700, 16'h0600);
    rd(imsk_pkg::ADDR_CLEAR_ALL);
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("all clr", d & 16'h0FEB, 16'h0000);
    $display("t_bus done");
  endtask

  // Threshold edge, then the disabled controller with and without activity.
  task automatic t_empty();
    pulse(0);
    tx_threshold = 5'h05;
    tx_level = 6'h05;
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("at thr", d[4], 1'b1);
    tx_level = 6'h06;
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("above thr", d[4], 1'b0);
    // Lower levels mirror into raw bits 2 and 0; bit 2 is forced low once disabled.
    evt = imsk_pkg::imsk_evt_t'(8'h03);
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("levels on", d & 16'h0005, 16'h0005);
    controller_on = 1'b0;
    sm_active = 1'b1;
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("off busy", d & 16'h0810, 16'h0010);
    chk("levels off", d & 16'h0005, 16'h0001);
    chk("off flush", tx_flush, 1'b1);
    sm_active = 1'b0;
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("off idle", d & 16'h0910, 16'h0000);
    controller_on = 1'b1;
    tx_level = 6'h00;
    evt = '0;
    $display("t_empty done");
  endtask

  // Full buffers overflow, the byte is dropped, and disabled idle clears both.
  task automatic t_over();
    tx_level = 6'h20;
    rx_level = 6'h20;
    pulse(4);
    pulse(5);
    chk("drop", rx_drop, 1'b1);
    tick();
    chk("drop once", rx_drop, 1'b0);
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("over", d & 16'h000A, 16'h000A);
    controller_on = 1'b0;
    sm_active = 1'b1;
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("over held", d & 16'h000A, 16'h000A);
    sm_active = 1'b0;
    rd(imsk_pkg::ADDR_IRQ_RAW_STATUS);
    chk("over idle", d & 16'h000A, 16'h0000);
    // A reset in mid-run must bring back the mask's reset value.
    srst = 1'b1;
    repeat (4) tick();
    srst = 1'b0;
    rd(imsk_pkg::ADDR_IRQ_MASK);
    chk("mask re-reset", d, 16'h08FF);
    $display("t_over done");
  endtask

  // Hang guard, well beyond the expected run of under two hundred cycles.
  initial
  begin
    #200000;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    end_sim();
  end

  // Main sequence.
  initial
  begin
    err_total = 0;
    check_count = 0;
    srst = 1'b1;
    reg_addr = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    controller_on = 1'b1;
    sm_active = 1'b0;
    tx_level = 6'h00;
    tx_threshold = 5'h00;
    rx_level = 6'h00;
    evt = '0;
    repeat (12) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_regs();
    t_flags();
    t_bus();
    t_empty();
    t_over();
    end_sim();
  end
endmodule
